/* wdtcr_pkg.sv */
// Watchdog package: register map, field positions, reset values, counts.
// Assumes the block clock is the crystal oscillator clock.
package wdtcr_pkg;

   //////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on an 18-bit APB address
   localparam int ADDR_W = 18;
   localparam logic [17:0] CTRL_ADDR = 18'h00000;
   localparam logic [17:0] STATUS_ADDR = 18'h00004;
   localparam logic [17:0] MASK_ADDR = 18'h00008;
   localparam logic [17:0] CAUSE_ADDR = 18'h0000c;
   localparam logic [17:0] COUNT_ADDR = 18'h00010;
   // Service port index; byte address is four times the index
   localparam logic [15:0] SERVICE_INDEX = 16'hffff;
   localparam logic [17:0] SERVICE_ADDR = {SERVICE_INDEX, 2'b00};

   //////////////////////////////////////////////////////////////////////
   // Fields and reset values
   localparam int CTRL_RATE_BIT = 0;
   localparam int CTRL_DISABLE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int EV_W = 2;
   localparam int EV_TIMEOUT_BIT = 0;
   localparam int EV_SERVICE_BIT = 1;
   localparam logic [1:0] EV_RESET = 2'h0;
   localparam int CAUSE_WD_BIT = 0;

   //////////////////////////////////////////////////////////////////////
   // Timebase
   localparam int PRE_W = 12;
   localparam int CNT_W = 6;
   localparam int SVC_LOW_BIT = 3;
   localparam int TIMEOUT_SHORT_CYC = 8176;
   localparam int TIMEOUT_LONG_CYC = 262128;
   localparam int RESET_PULSE_CYC = 32;
   localparam int POR_CLEAR_CYC = 4096;

   typedef enum logic [1:0] {
      WD_RUN = 2'b01,
      WD_PULSE = 2'b10
   } wdtcr_state_e;

   // Address compare used by both decode paths
   function automatic logic isAddr(input logic [17:0] a,
                                   input logic [17:0] b);
      isAddr = (a == b);
   endfunction

endpackage

/* wdtcr_sync.sv */
// Two-flop level synchroniser for pin inputs.
// Assumes inputs are quasi-static levels.
`timescale 1ns/100ps
module wdtcr_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Levels
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stage1_reg <= '0;
         dout <= '0;
      end else begin
         stage1_reg <= din;
         dout <= stage1_reg;
      end
   end
endmodule // wdtcr_sync

/* wdtcr_timebase.sv */
// Watchdog prescaler and counter with rate-selected overflow.
// Assumes clear and run controls come from the same clock domain.
`timescale 1ns/100ps
module wdtcr_timebase import wdtcr_pkg::*; #(
   parameter int PRE_WIDTH = PRE_W,
   parameter int CNT_WIDTH = CNT_W,
   parameter int LONG_CYC = TIMEOUT_LONG_CYC,
   parameter int SHORT_CYC = TIMEOUT_SHORT_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Controls
   input wire logic clearAll,
   input wire logic clearPre,
   input wire logic service,
   input wire logic run,
   input wire logic rateShort,
   // State
   output logic [CNT_WIDTH-1:0] count,
   output logic overflow
);
   localparam int TOT_W = PRE_WIDTH + CNT_WIDTH;
   localparam logic [PRE_WIDTH-1:0] KEEP_MASK =
      PRE_WIDTH'((1 << SVC_LOW_BIT) - 1);
   localparam logic [TOT_W-1:0] LONG_TERM = TOT_W'(LONG_CYC - 1);
   localparam logic [TOT_W-1:0] SHORT_TERM = TOT_W'(SHORT_CYC - 1);

   logic [PRE_WIDTH-1:0] pre_reg;
   logic [TOT_W-1:0] terminal;

   assign terminal = rateShort ? SHORT_TERM : LONG_TERM;
   assign overflow = run && ({count, pre_reg} == terminal);

   // Prescaler
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre_reg <= '0;
      end else if (clearAll || overflow) begin
         pre_reg <= '0;
      end else if (clearPre) begin
         pre_reg <= '0;
      end else if (service) begin
         pre_reg <= pre_reg & KEEP_MASK;
      end else if (run) begin
         pre_reg <= pre_reg + 1'b1;
      end
   end

   // Counter advances on prescaler rollover
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else if (clearAll || overflow || service) begin
         count <= '0;
      end else if (run && (&pre_reg)) begin
         count <= count + 1'b1;
      end
   end
endmodule // wdtcr_timebase

/* wdtcr_top.sv */
// Watchdog top: APB registers, service port, reset pulse, disables.
// Assumes clock is the crystal oscillator clock; mode inputs are
// synchronous, test-voltage detect inputs come from pins.
//
// Functional notes
// - 6-bit counter fed by 12-bit prescaler, both on oscillator clock.
// - Unserviced overflow raises reset after 8176 or 262128 cycles.
// - Rate bit one gives 8176 cycles, zero 262128; reset clears it.
// - Any write to service port clears counter and prescaler stages 4-12.
// - Service port read returns reset vector low byte, no side effect.
// - Watchdog reset drives reset pin low 32 cycles, sets cause flag.
// - Power-on logic clears prescaler 4096 cycles after power-up.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Stop instruction execution clears the prescaler.
// - Stop mode gates counting off entirely.
// - Counting and reset continue during wait mode.
// - Monitor mode with test voltage on either pin disables watchdog.
// - Break state with test voltage on reset pin disables watchdog.
// - Disable bit one makes watchdog inactive, zero enables it.
// - Watchdog's CPU request is the masked status irq; its main action is system reset.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module wdtcr_top import wdtcr_pkg::*; #(
   parameter int LONG_CYC = TIMEOUT_LONG_CYC,
   parameter int SHORT_CYC = TIMEOUT_SHORT_CYC,
   parameter logic [7:0] RESET_VECTOR_LO = 8'h00
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // APB slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Chip mode and event inputs
   input wire logic internalReset,
   input wire logic vectorFetch,
   input wire logic stopExec,
   input wire logic stopMode,
   input wire logic monitorMode,
   input wire logic breakState,
   // Test-voltage detect pins
   input wire logic vtstIrqPin,
   input wire logic vtstRstPin,
   // Reset outputs
   output logic resetPinOut,
   output logic resetPinOe,
   output logic systemResetReq,
   // Status interrupt
   output logic irq
);

   /////////////////////////////////////////////////////////////////////
   // Declarations
   wdtcr_state_e state_reg;
   wdtcr_state_e state_next;
   logic [1:0] ctrl_reg;
   logic [EV_W-1:0] status_reg;
   logic [EV_W-1:0] status_next;
   logic [EV_W-1:0] mask_reg;
   logic cause_reg;
   logic cause_next;
   logic [4:0] pulseCnt_reg;
   logic [11:0] porCnt_reg;
   logic porDone_reg;
   logic porClear;
   logic [1:0] vtstSync;
   logic vtstIrqS;
   logic vtstRstS;
   logic vtstDisable;
   logic run;
   logic wdOverflow;
   logic [CNT_W-1:0] wdCount;
   logic setupPhase;
   logic accessPhase;
   logic writeEn;
   logic svcWrite;
   logic regWrite;
   logic mapped;
   logic [EV_W-1:0] evSet;

   /////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   wdtcr_sync #(
      .WIDTH(2)
   ) u_sync (
      .clock(clock),
      .rst(rst),
      .din({vtstIrqPin, vtstRstPin}),
      .dout(vtstSync)
   );

   assign vtstIrqS = vtstSync[1];
   assign vtstRstS = vtstSync[0];

   assign vtstDisable = (monitorMode && (vtstIrqS || vtstRstS))
      || (breakState && vtstRstS);

   // Wait mode is not an input: counting goes on through it
   assign run = !ctrl_reg[CTRL_DISABLE_BIT]
      && !stopMode
      && !vtstDisable
      && (state_reg == WD_RUN);

   /////////////////////////////////////////////////////////////////////
   // APB decode
   assign setupPhase = psel && !penable;
   assign accessPhase = psel && penable;
   assign pready = 1'b1;
   assign writeEn = accessPhase && pwrite;
   assign svcWrite = writeEn && isAddr(paddr, SERVICE_ADDR);
   assign regWrite = writeEn && pstrb[0];

   always_comb begin
      mapped = isAddr(paddr, CTRL_ADDR) || isAddr(paddr, STATUS_ADDR)
         || isAddr(paddr, MASK_ADDR) || isAddr(paddr, CAUSE_ADDR)
         || isAddr(paddr, COUNT_ADDR) || isAddr(paddr, SERVICE_ADDR);
   end

   // Read data captured in setup, valid through the access phase
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         pslverr <= !mapped;
         if (pwrite || !mapped) begin
            prdata <= 32'h00000000;
         end else if (isAddr(paddr, CTRL_ADDR)) begin
            prdata <= {30'h00000000, ctrl_reg};
         end else if (isAddr(paddr, STATUS_ADDR)) begin
            prdata <= {30'h00000000, status_reg};
         end else if (isAddr(paddr, MASK_ADDR)) begin
            prdata <= {30'h00000000, mask_reg};
         end else if (isAddr(paddr, CAUSE_ADDR)) begin
            prdata <= {31'h00000000, cause_reg};
         end else if (isAddr(paddr, COUNT_ADDR)) begin
            prdata <= {26'h0000000, wdCount};
         end else begin
            prdata <= {24'h000000, RESET_VECTOR_LO};
         end
      end
   end

   /////////////////////////////////////////////////////////////////////
   // Configuration register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (internalReset) begin
         ctrl_reg <= CTRL_RESET;
      end else if (regWrite && isAddr(paddr, CTRL_ADDR)) begin
         ctrl_reg <= pwdata[1:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask_reg <= EV_RESET;
      end else if (regWrite && isAddr(paddr, MASK_ADDR)) begin
         mask_reg <= pwdata[EV_W-1:0];
      end
   end

   /////////////////////////////////////////////////////////////////////
   // Sticky status and reset cause, set wins over clear
   always_comb begin
      evSet = EV_RESET;
      evSet[EV_TIMEOUT_BIT] = wdOverflow;
      evSet[EV_SERVICE_BIT] = svcWrite;
      status_next = status_reg;
      if (regWrite && isAddr(paddr, STATUS_ADDR)) begin
         status_next = status_reg & ~pwdata[EV_W-1:0];
      end
      status_next = status_next | evSet;
      cause_next = cause_reg;
      if (regWrite && isAddr(paddr, CAUSE_ADDR)
          && pwdata[CAUSE_WD_BIT]) begin
         cause_next = 1'b0;
      end
      if (wdOverflow) begin
         cause_next = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status_reg <= EV_RESET;
         cause_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         cause_reg <= cause_next;
      end
   end

   assign irq = |(status_reg & mask_reg);

   /////////////////////////////////////////////////////////////////////
   // Power-on prescaler clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         porCnt_reg <= 12'h000;
         porDone_reg <= 1'b0;
      end else if (!porDone_reg) begin
         porCnt_reg <= porCnt_reg + 12'h001;
         if (porCnt_reg == 12'(POR_CLEAR_CYC - 1)) begin
            porDone_reg <= 1'b1;
         end
      end
   end

   assign porClear = !porDone_reg
      && (porCnt_reg == 12'(POR_CLEAR_CYC - 1));

   /////////////////////////////////////////////////////////////////////
   // Timebase
   wdtcr_timebase #(
      .PRE_WIDTH(PRE_W),
      .CNT_WIDTH(CNT_W),
      .LONG_CYC(LONG_CYC),
      .SHORT_CYC(SHORT_CYC)
   ) u_timebase (
      .clock(clock),
      .rst(rst),
      .clearAll(internalReset || (state_reg == WD_PULSE)),
      .clearPre(porClear || vectorFetch || stopExec),
      .service(svcWrite),
      .run(run),
      .rateShort(ctrl_reg[CTRL_RATE_BIT]),
      .count(wdCount),
      .overflow(wdOverflow)
   );

   /////////////////////////////////////////////////////////////////////
   // Reset pulse sequencer
   always_comb begin
      case (state_reg)
         WD_RUN: begin
            state_next = wdOverflow ? WD_PULSE : WD_RUN;
         end
         WD_PULSE: begin
            if (pulseCnt_reg == 5'(RESET_PULSE_CYC - 1)) begin
               state_next = WD_RUN;
            end else begin
               state_next = WD_PULSE;
            end
         end
         default: begin
            state_next = WD_RUN;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= WD_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pulseCnt_reg <= 5'h00;
      end else if (state_reg == WD_PULSE) begin
         pulseCnt_reg <= pulseCnt_reg + 5'h01;
      end else begin
         pulseCnt_reg <= 5'h00;
      end
   end

   // Reset outputs; the only CPU request path is the masked status irq
   assign resetPinOut = 1'b0;
   assign resetPinOe = state_reg[1];
   assign systemResetReq = state_reg[1];

   /////////////////////////////////////////////////////////////////////
   // Assertions
   a_service_clears: assert property (
      @(posedge clock) disable iff (rst)
      svcWrite |=> (wdCount == '0))
      else $error("service write did not clear the counter");

   a_vector_read: assert property (
      @(posedge clock) disable iff (rst)
      accessPhase && !pwrite && isAddr(paddr, SERVICE_ADDR)
      |-> (prdata == {24'h000000, RESET_VECTOR_LO}) && !pslverr)
      else $error("service port read did not return vector byte");

   a_pulse_length: assert property (
      @(posedge clock) disable iff (rst)
      $rose(resetPinOe) |-> ##31 resetPinOe ##1 !resetPinOe)
      else $error("reset pin pulse is not 32 cycles");

   a_cause_flag: assert property (
      @(posedge clock) disable iff (rst)
      wdOverflow |=> cause_reg && systemResetReq)
      else $error("overflow did not set cause and request reset");

   a_disabled_quiet: assert property (
      @(posedge clock) disable iff (rst)
      ctrl_reg[CTRL_DISABLE_BIT] |-> !wdOverflow)
      else $error("overflow while watchdog disabled");

   a_stop_holds: assert property (
      @(posedge clock) disable iff (rst)
      stopMode && !internalReset && !svcWrite && (state_reg == WD_RUN)
      |=> $stable(wdCount))
      else $error("counter moved in stop mode");

   a_monitor_off: assert property (
      @(posedge clock) disable iff (rst)
      monitorMode && (vtstIrqS || vtstRstS) |-> !wdOverflow)
      else $error("overflow in monitor mode with test voltage");

   a_break_off: assert property (
      @(posedge clock) disable iff (rst)
      breakState && vtstRstS |-> !wdOverflow)
      else $error("overflow in break state with test voltage");

   a_internal_clear: assert property (
      @(posedge clock) disable iff (rst)
      internalReset |=> (wdCount == '0) && !ctrl_reg[CTRL_RATE_BIT])
      else $error("internal reset did not clear watchdog state");

   a_por_once: assert property (
      @(posedge clock) disable iff (rst)
      porClear |=> porDone_reg ##1 !porClear)
      else $error("power-on prescaler clear not single");

endmodule // wdtcr_top

/* wdtcr_top_tb.sv */
// Testbench for the watchdog top: registers, timeouts, disables, clears.
// Assumes shortened timeout parameters and a zero-wait APB slave.
`timescale 1ns/100ps
module wdtcr_top_tb import wdtcr_pkg::*;;
   localparam int T_LONG = 4200;
   localparam int T_SHORT = 100;
   localparam logic [7:0] VEC_LO = 8'h5a;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic [17:0] paddr = 18'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, resetPinOut, resetPinOe, systemResetReq, irq;
   logic internalReset = 1'h0;
   logic vectorFetch = 1'h0;
   logic stopExec = 1'h0;
   logic stopMode = 1'h0;
   logic monitorMode = 1'h0;
   logic breakState = 1'h0;
   logic vtstIrqPin = 1'h0;
   logic vtstRstPin = 1'h0;
   int errCount = 0;
   int totalChecks = 0;

   wdtcr_top #(.LONG_CYC(T_LONG), .SHORT_CYC(T_SHORT),
      .RESET_VECTOR_LO(VEC_LO)) u_dut (.clock(clock), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .internalReset(internalReset),
      .vectorFetch(vectorFetch), .stopExec(stopExec), .stopMode(stopMode),
      .monitorMode(monitorMode), .breakState(breakState),
      .vtstIrqPin(vtstIrqPin), .vtstRstPin(vtstRstPin),
      .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
      .systemResetReq(systemResetReq), .irq(irq));

   always #12.5 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////
   task automatic endSim();
      $display("checks %0d mismatches %0d", totalChecks, errCount);
      if (errCount == 0 && totalChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [17:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      @(posedge clock);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'h1, a, d, rd, err);
   endtask

   task automatic rdChk(input logic [17:0] a, input logic [31:0] exp,
                        input logic expErr);
      logic [31:0] rd;
      logic err;
      apb(1'h0, a, 32'h0, rd, err);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, expErr});
   endtask

   // Counts cycles to the reset pulse, then its width
   task automatic expectReset(input int lo, input int hi);
      int n;
      n = 0;
      while (systemResetReq !== 1'h1 && n <= hi) begin
         @(posedge clock);
         n++;
      end
      chk(32'(n >= lo && n <= hi), 32'h1);
      chk({30'h0, resetPinOe, resetPinOut}, 32'h2);
      n = 0;
      while (systemResetReq === 1'h1 && n < 40) begin
         @(posedge clock);
         n++;
      end
      chk(32'(n), 32'(RESET_PULSE_CYC));
   endtask

   task automatic noReset(input int cyc);
      int bad;
      bad = 0;
      repeat (cyc) begin
         @(posedge clock);
         if (systemResetReq !== 1'h0) bad++;
      end
      chk(32'(bad), 32'h0);
   endtask

   task automatic chkIrq(input logic exp);
      repeat (2) @(posedge clock);
      chk({31'h0, irq}, {31'h0, exp});
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic tResetValues();
      rdChk(CTRL_ADDR, 32'h0, 1'h0);
      rdChk(STATUS_ADDR, 32'h0, 1'h0);
      rdChk(CAUSE_ADDR, 32'h0, 1'h0);
      rdChk(SERVICE_ADDR, {24'h0, VEC_LO}, 1'h0);
      rdChk(18'h00020, 32'h0, 1'h1);
   endtask

   task automatic tShortFlags();
      wr(MASK_ADDR, 32'h1);
      wr(CTRL_ADDR, 32'h1);
      wr(SERVICE_ADDR, 32'h0);
      expectReset(T_SHORT - 9, T_SHORT + 3);
      chkIrq(1'h1);
      rdChk(CAUSE_ADDR, 32'h1, 1'h0);
      rdChk(STATUS_ADDR, 32'h3, 1'h0);
      wr(CAUSE_ADDR, 32'h1);
      wr(STATUS_ADDR, 32'h3);
      chkIrq(1'h0);
      rdChk(CAUSE_ADDR, 32'h0, 1'h0);
   endtask

   task automatic tLongMask();
      wr(CTRL_ADDR, 32'h0);
      wr(SERVICE_ADDR, 32'h0);
      expectReset(T_LONG - 9, T_LONG + 3);
      wr(MASK_ADDR, 32'h0);
      chkIrq(1'h0);
      wr(MASK_ADDR, 32'h1);
      chkIrq(1'h1);
      wr(STATUS_ADDR, 32'h3);
      chkIrq(1'h0);
   endtask

   task automatic tKeepAlive();
      wr(CTRL_ADDR, 32'h1);
      for (int i = 0; i < 6; i++) begin
         wr(SERVICE_ADDR, 32'(i * 32'h11));
         noReset(T_SHORT - 40);
      end
      rdChk(SERVICE_ADDR, {24'h0, VEC_LO}, 1'h0);
      expectReset(T_SHORT - 70, T_SHORT - 61);
   endtask

   task automatic tClears();
      for (int i = 0; i < 2; i++) begin
         wr(SERVICE_ADDR, 32'h0);
         repeat (60) @(posedge clock);
         if (i == 0) vectorFetch <= 1'h1;
         else stopExec <= 1'h1;
         @(posedge clock);
         vectorFetch <= 1'h0;
         stopExec <= 1'h0;
         expectReset(T_SHORT - 2, T_SHORT + 3);
      end
   endtask

   task automatic tDisables();
      logic [4:0] cfg [4] = '{5'h10, 5'h0c, 5'h09, 5'h03};
      for (int i = 0; i < 4; i++) begin
         {stopMode, monitorMode, vtstIrqPin, breakState, vtstRstPin}
            <= cfg[i];
         wr(SERVICE_ADDR, 32'h0);
         noReset(T_SHORT + 60);
         {stopMode, monitorMode, vtstIrqPin, breakState, vtstRstPin}
            <= 5'h0;
         @(posedge clock);
      end
   endtask

   task automatic tInternal();
      wr(CTRL_ADDR, 32'h0);
      wr(SERVICE_ADDR, 32'h0);
      repeat (4100) @(posedge clock);
      rdChk(COUNT_ADDR, 32'h1, 1'h0);
      wr(CTRL_ADDR, 32'h3);
      @(posedge clock);
      internalReset <= 1'h1;
      @(posedge clock);
      internalReset <= 1'h0;
      rdChk(CTRL_ADDR, 32'h0, 1'h0);
      rdChk(COUNT_ADDR, 32'h0, 1'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'h0;
      tResetValues();
      wr(CTRL_ADDR, 32'h2);
      noReset(4200);
      tShortFlags();
      tLongMask();
      tKeepAlive();
      tClears();
      wr(CTRL_ADDR, 32'h1);
      tDisables();
      tInternal();
      endSim();
   end

   initial begin
      repeat (30000) @(posedge clock);
      errCount++;
      $display("[FAIL] %0t watchdog limit reached", $time);
      endSim();
   end
endmodule // wdtcr_top_tb
